/* File: verilog/aphi_defs.svh */
// aphi_defs.svh: offsets, field positions and reset values of the host port
// assumes: included by bare name from aphi_top
`ifndef APHI_DEFS_SVH
`define APHI_DEFS_SVH

// host-side control registers, picked by the two upper data lines
`define APHI_HOST_CR0      2'h0
`define APHI_HOST_CR1      2'h1
`define APHI_CR_W          10
`define APHI_CR0_RESET     10'h000
`define APHI_CR1_RESET     10'h000

// control register 0 fields
`define APHI_CR0_EXTREF    2

// control register 1 fields
`define APHI_CR1_WRONLY    0
`define APHI_CR1_AVHIGH    1
`define APHI_CR1_AVPULSE   2
`define APHI_CR1_CONTMODE  3
`define APHI_CR1_TRIG_LO   4
`define APHI_CR1_TRIG_HI   7

// software register offsets
`define APHI_SW_STATUS     8'h00
`define APHI_SW_MASK       8'h04
`define APHI_SW_CR0        8'h08
`define APHI_SW_CR1        8'h0C
`define APHI_SW_LEVEL      8'h10

// status bits
`define APHI_ST_W          4
`define APHI_ST_OVERFLOW   0
`define APHI_ST_UNDERFLOW  1
`define APHI_ST_READY      2
`define APHI_ST_EARLYRD    3
`define APHI_MASK_RESET    4'h0

`endif

/* File: verilog/aphi_pkg.sv */
// aphi_pkg: types shared by the host port modules
// assumes: aphi_defs.svh is on the include path
package aphi_pkg;

	// host access sequencer, gray along idle-read and idle-write
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_READ  = 2'b01,
		ST_WRITE = 2'b10
	} aphi_bus_e;

	// host pins as sampled, one bundle through the synchroniser
	typedef struct packed {
		logic        convN;
		logic        rdN;
		logic        wrN;
		logic        selHigh;
		logic        selLowN;
		logic [11:0] data;
	} aphi_pins_s;

	// software register request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} aphi_swreq_s;

endpackage : aphi_pkg

/* File: verilog/aphi_sync.sv */
// aphi_sync: three-stage pin synchroniser with agreement filter
// assumes: pins are asynchronous to clock; one clock domain
`timescale 1ns/100ps
`default_nettype none

module aphi_sync #(
	parameter int WIDTH = 17
) (
	// system
	input  wire logic             clock,
	input  wire logic             rstn,
	input  wire logic             ce,
	// pins and filtered result
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinOut
);

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] agree;

	// first stage feeds only the second stage; all stages start at the
	// idle-high pin level, so no false falling edge follows reset
	always_ff @(posedge clock) begin
		if (!rstn) begin
			s1_q <= '1;
			s2_q <= '1;
			s3_q <= '1;
		end else if (ce) begin
			s1_q <= pinIn;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign agree = ~(s2_q ^ s3_q);

	// a bit changes only once two stages agree, which hides one-cycle glitches
	always_ff @(posedge clock) begin
		if (!rstn) begin
			pinOut <= '1;
		end else if (ce) begin
			pinOut <= (pinOut & ~agree) | (s3_q & agree);
		end
	end

endmodule : aphi_sync

`default_nettype wire

/* File: verilog/aphi_mem.sv */
// aphi_mem: result store with one write and one registered read port
// assumes: caller keeps pointers in range and never reads an empty slot
`timescale 1ns/100ps
`default_nettype none

module aphi_mem #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	// system
	input  wire logic             clock,
	input  wire logic             rstn,
	input  wire logic             ce,
	// write port
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	// read port
	input  wire logic             re,
	input  wire logic [AW-1:0]    raddr,
	output logic      [WIDTH-1:0] rdata
);

	logic [WIDTH-1:0] store [DEPTH];

	// array holds no reset, so it maps onto plain ram cells
	always_ff @(posedge clock) begin
		if (ce && we) begin
			store[waddr] <= wdata;
		end
	end

	// read data stand in a register until the next read
	always_ff @(posedge clock) begin
		if (!rstn) begin
			rdata <= '0;
		end else if (ce && re) begin
			rdata <= store[raddr];
		end
	end

endmodule : aphi_mem

`default_nettype wire

/* File: verilog/aphi_top.sv */
// aphi_top: processor-side parallel port of a sampling converter
// assumes: converter logic on clock delivers results; software on a plain port
`timescale 1ns/100ps
`default_nettype none

`include "aphi_defs.svh"

module aphi_top
	import aphi_pkg::*;
#(
	parameter int DATA_W = 12,
	parameter int DEPTH  = 16,
	parameter int AW     = 4
) (
	// system
	input  wire logic              clock,
	input  wire logic              rstn,
	input  wire logic              ce,
	// host pins
	input  wire logic [DATA_W-1:0] hostDataBusIn,
	output logic      [DATA_W-1:0] hostDataBusOut,
	output logic                   hostDataBusOe,
	input  wire logic              selectActiveLowN,
	input  wire logic              selectActiveHigh,
	input  wire logic              writeStrobeN,
	input  wire logic              readStrobeN,
	input  wire logic              conversionStartN,
	output logic                   resultReadyFlag,
	// converter side
	input  wire logic              resultValid,
	input  wire logic [DATA_W-1:0] resultData,
	output logic                   convStartPulse,
	output logic                   convClockTick,
	output logic                   continuousMode,
	output logic                   extRefSelect,
	// software register port
	input  wire logic              swWr,
	input  wire logic              swRd,
	input  wire logic [7:0]        swAddr,
	input  wire logic [15:0]       swWdata,
	output logic      [15:0]       swRdata,
	// interrupt
	output logic                   irq
);

	// true when a software access hits the given offset
	function automatic logic swHit(input logic strobe, input logic [7:0] addr,
	                               input logic [7:0] off);
		swHit = strobe && (addr == off);
	endfunction : swHit

	aphi_pins_s            pinRaw;
	aphi_pins_s            pin;
	aphi_swreq_s           sw;
	aphi_bus_e             state_q;
	aphi_bus_e             state_d;
	logic [`APHI_CR_W-1:0] cr0_q;
	logic [`APHI_CR_W-1:0] cr1_q;
	logic                  cfgValid_q;
	logic [DATA_W-1:0]     wrData_q;
	logic [AW-1:0]         wrPtr_q;
	logic [AW-1:0]         rdPtr_q;
	logic [AW:0]           count_q;
	logic [DATA_W-1:0]     memRdata;
	logic                  selected;
	logic                  wantWrite;
	logic                  wantRead;
	logic                  earlyCond;
	logic                  earlyCond_q;
	logic                  commit;
	logic                  readStart;
	logic                  push;
	logic                  pop;
	logic                  full;
	logic                  empty;
	logic [AW:0]           thresh;
	logic                  avCond;
	logic                  avCond_q;
	logic                  avActive;
	logic                  convPrev_q;
	logic [`APHI_ST_W-1:0] status_q;
	logic [`APHI_ST_W-1:0] mask_q;
	logic [`APHI_ST_W-1:0] events;

	assign sw = '{wr: swWr, rd: swRd, addr: swAddr, wdata: swWdata};

	// all host pins go through the same filter so their skew stays aligned
	assign pinRaw = '{convN: conversionStartN, rdN: readStrobeN, wrN: writeStrobeN,
	                  selHigh: selectActiveHigh, selLowN: selectActiveLowN,
	                  data: hostDataBusIn};

	aphi_sync #(
		.WIDTH ($bits(aphi_pins_s))
	) u_sync (
		.clock  (clock),
		.rstn   (rstn),
		.ce     (ce),
		.pinIn  (pinRaw),
		.pinOut (pin)
	);

	// access qualification
	assign selected  = pin.selHigh && !pin.selLowN;
	// write pin low means write in both strobe settings, so the first
	// write is understood before the setting is known
	assign wantWrite = selected && !pin.wrN;
	// read needs a known setting; the read strobe counts only in strobe mode
	assign wantRead  = selected && cfgValid_q && pin.wrN &&
	                   (cr1_q[`APHI_CR1_WRONLY] ? !pin.rdN : 1'b1);
	assign earlyCond = selected && !cfgValid_q && pin.wrN && !pin.rdN;

	// host access sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (wantWrite) begin
					state_d = ST_WRITE;
				end else if (wantRead) begin
					state_d = ST_READ;
				end
			end
			ST_WRITE: begin
				if (!wantWrite) begin
					state_d = ST_IDLE;
				end
			end
			ST_READ: begin
				if (!wantRead) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			state_q <= ST_IDLE;
		end else if (ce) begin
			state_q <= state_d;
		end
	end

	// commit on the trailing edge, when the host data are surely settled
	assign commit    = (state_q == ST_WRITE) && !wantWrite;
	assign readStart = (state_q == ST_IDLE) && !wantWrite && wantRead;

	// write data follow the bus for the whole write
	always_ff @(posedge clock) begin
		if (!rstn) begin
			wrData_q <= '0;
		end else if (ce && wantWrite) begin
			wrData_q <= pin.data;
		end
	end

	// control registers, chosen by the two upper data lines
	// codes two and three are dropped, yet still count as the first write
	always_ff @(posedge clock) begin
		if (!rstn) begin
			cr0_q <= `APHI_CR0_RESET;
			cr1_q <= `APHI_CR1_RESET;
		end else if (ce && commit) begin
			case (wrData_q[DATA_W-1 -: 2])
				`APHI_HOST_CR0: cr0_q <= wrData_q[`APHI_CR_W-1:0];
				`APHI_HOST_CR1: cr1_q <= wrData_q[`APHI_CR_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// any finished write makes the strobe setting known
	always_ff @(posedge clock) begin
		if (!rstn) begin
			cfgValid_q <= 1'b0;
		end else if (ce && commit) begin
			cfgValid_q <= 1'b1;
		end
	end

	// result store pointers and fill count; a result that meets a full
	// store is dropped and only logged, since the converter cannot be
	// held off, so software has to watch the overflow bit
	assign full  = (count_q == (AW+1)'(DEPTH));
	assign empty = (count_q == '0);
	assign push  = resultValid && !full;
	assign pop   = readStart && !empty;

	always_ff @(posedge clock) begin
		if (!rstn) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else if (ce) begin
			if (push) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
			case ({push, pop})
				2'b10:   count_q <= count_q + 1'b1;
				2'b01:   count_q <= count_q - 1'b1;
				default: count_q <= count_q;
			endcase
		end
	end

	aphi_mem #(
		.WIDTH (DATA_W),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_mem (
		.clock (clock),
		.rstn  (rstn),
		.ce    (ce),
		.we    (push),
		.waddr (wrPtr_q),
		.wdata (resultData),
		.re    (pop),
		.raddr (rdPtr_q),
		.rdata (memRdata)
	);

	// bus drive: the registered word, lsb on line 0, only while reading
	// an empty-store read still drives the last word and logs an underflow
	assign hostDataBusOut = memRdata;
	assign hostDataBusOe  = (state_q == ST_READ);

	// threshold of zero is taken as one so the flag can never stick on
	assign thresh = (cr1_q[`APHI_CR1_TRIG_HI:`APHI_CR1_TRIG_LO] == 4'h0) ?
	                (AW+1)'(1) :
	                (AW+1)'(cr1_q[`APHI_CR1_TRIG_HI:`APHI_CR1_TRIG_LO]);
	assign avCond   = (count_q >= thresh);
	assign avActive = cr1_q[`APHI_CR1_AVPULSE] ? (avCond && !avCond_q) : avCond;

	// data-available flag drawn from a flop at the selected polarity
	always_ff @(posedge clock) begin
		if (!rstn) begin
			avCond_q        <= 1'b0;
			resultReadyFlag <= 1'b1;
		end else if (ce) begin
			avCond_q        <= avCond;
			resultReadyFlag <= cr1_q[`APHI_CR1_AVHIGH] ? avActive : !avActive;
		end
	end

	// conversion start or conversion clock, from the same pin
	// the mode bit is read as it stood before the edge, so a mode write
	// and a pin edge in one cycle act under the old mode
	always_ff @(posedge clock) begin
		if (!rstn) begin
			convPrev_q     <= 1'b1;
			convStartPulse <= 1'b0;
			convClockTick  <= 1'b0;
		end else if (ce) begin
			convPrev_q     <= pin.convN;
			convStartPulse <= !continuousMode && convPrev_q && !pin.convN;
			convClockTick  <= continuousMode && !convPrev_q && pin.convN;
		end
	end

	// converter configuration straight from the control registers
	assign continuousMode = cr1_q[`APHI_CR1_CONTMODE];
	assign extRefSelect   = cr0_q[`APHI_CR0_EXTREF];

	// events: lost result, read of an empty store, flag rise, read before setup
	always_comb begin
		events = '0;
		events[`APHI_ST_OVERFLOW]  = resultValid && full;
		events[`APHI_ST_UNDERFLOW] = readStart && empty;
		events[`APHI_ST_READY]     = avCond && !avCond_q;
		events[`APHI_ST_EARLYRD]   = earlyCond && !earlyCond_q;
	end

	// sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge clock) begin
		if (!rstn) begin
			status_q    <= '0;
			earlyCond_q <= 1'b0;
		end else if (ce) begin
			earlyCond_q <= earlyCond;
			if (swHit(sw.wr, sw.addr, `APHI_SW_STATUS)) begin
				status_q <= (status_q & ~sw.wdata[`APHI_ST_W-1:0]) | events;
			end else begin
				status_q <= status_q | events;
			end
		end
	end

	// interrupt mask
	always_ff @(posedge clock) begin
		if (!rstn) begin
			mask_q <= `APHI_MASK_RESET;
		end else if (ce && swHit(sw.wr, sw.addr, `APHI_SW_MASK)) begin
			mask_q <= sw.wdata[`APHI_ST_W-1:0];
		end
	end

	assign irq = |(status_q & mask_q);

	// software read data stand one cycle after the strobe, zero otherwise
	always_ff @(posedge clock) begin
		if (!rstn) begin
			swRdata <= '0;
		end else if (ce) begin
			swRdata <= '0;
			if (swHit(sw.rd, sw.addr, `APHI_SW_STATUS)) begin
				swRdata <= 16'(status_q);
			end else if (swHit(sw.rd, sw.addr, `APHI_SW_MASK)) begin
				swRdata <= 16'(mask_q);
			end else if (swHit(sw.rd, sw.addr, `APHI_SW_CR0)) begin
				swRdata <= 16'(cr0_q);
			end else if (swHit(sw.rd, sw.addr, `APHI_SW_CR1)) begin
				swRdata <= 16'(cr1_q);
			end else if (swHit(sw.rd, sw.addr, `APHI_SW_LEVEL)) begin
				swRdata <= 16'({cfgValid_q, state_q, count_q});
			end
		end
	end

endmodule : aphi_top

`default_nettype wire

/* File: test/aphi_top_sva.sv */
// aphi_top_sva: port-level checks of the processor-side host port
// assumes: bound to aphi_top, one clock, ce held high by the bench
`timescale 1ns/100ps
`default_nettype none

module aphi_top_sva #(
	parameter int DATA_W = 12
) (
	// system
	input wire logic              clock,
	input wire logic              rstn,
	// inputs watched
	input wire logic              selectActiveLowN,
	input wire logic              selectActiveHigh,
	input wire logic              writeStrobeN,
	input wire logic              conversionStartN,
	input wire logic              resultValid,
	// outputs watched
	input wire logic [DATA_W-1:0] hostDataBusOut,
	input wire logic              hostDataBusOe,
	input wire logic              resultReadyFlag,
	input wire logic              convStartPulse,
	input wire logic              convClockTick,
	input wire logic              continuousMode,
	input wire logic              extRefSelect
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	// eight cycles cover the pin synchroniser and the state update behind it
	sequence deselIdle;
		selectActiveLowN [*8];
	endsequence
	sequence hostWriting;
		(!selectActiveLowN && selectActiveHigh && !writeStrobeN) [*8];
	endsequence
	sequence startHigh;
		conversionStartN [*8];
	endsequence
	sequence quiet;
		(selectActiveLowN && !resultValid) [*8];
	endsequence

	a_oe_needs_select: assert property (deselIdle |-> !hostDataBusOe)
		else $error("data bus driven while deselected");
	a_oe_off_write: assert property (hostWriting |-> !hostDataBusOe)
		else $error("data bus driven during a host write");
	a_word_held: assert property (hostDataBusOe && $past(hostDataBusOe) |-> $stable(hostDataBusOut))
		else $error("read word changed while driven");
	a_cfg_idle_stable: assert property (deselIdle |=> $stable(extRefSelect) && $stable(continuousMode))
		else $error("configuration changed without a host write");
	a_flag_quiet: assert property (quiet |=> $stable(resultReadyFlag))
		else $error("flag moved with no push, pop or write");
	a_start_one_cycle: assert property (convStartPulse |=> !convStartPulse)
		else $error("start pulse longer than one cycle");
	a_start_single: assert property (convStartPulse |-> !continuousMode)
		else $error("start pulse in continuous mode");
	a_tick_continuous: assert property (convClockTick |-> continuousMode)
		else $error("conversion tick in single mode");
	a_no_edge_quiet: assert property (startHigh |-> !convStartPulse && !convClockTick)
		else $error("start or tick with no pin edge");
endmodule : aphi_top_sva

bind aphi_top aphi_top_sva #(.DATA_W(DATA_W)) chk (
	.clock, .rstn, .selectActiveLowN, .selectActiveHigh, .writeStrobeN, .conversionStartN,
	.resultValid, .hostDataBusOut, .hostDataBusOe, .resultReadyFlag, .convStartPulse,
	.convClockTick, .continuousMode, .extRefSelect
);

`default_nettype wire

/* File: test/aphi_host_model.sv */
// aphi_host_model: processor on the parallel bus, selects, strobes, data lines
// assumes: the bench calls one task at a time; device output enable is high when driving
`timescale 1ns/100ps
`default_nettype none

module aphi_host_model (
	// system
	input  wire logic        clock,
	// device side of the data lines
	input  wire logic [11:0] devWord,
	input  wire logic        devOe,
	output logic      [11:0] busLevel,
	// selects and strobes
	output logic             selLowN,
	output logic             selHigh,
	output logic             wrN,
	output logic             rdN
);
	logic        drive = 1'h0;
	logic [11:0] word = 12'h000;
	logic [11:0] floatQ = 12'hA5A;

	// released lines wander each cycle so a stale word never passes as a read
	always @(posedge clock) floatQ <= ~busLevel;
	assign busLevel = devOe ? devWord : (drive ? word : floatQ);

	// idle: deselected, strobes released
	initial begin
		selLowN = 1'h1;
		selHigh = 1'h0;
		wrN = 1'h1;
		rdN = 1'h1;
	end

	// write: data held past the strobe so the last sample is still the word
	task automatic hostWrite(input logic [11:0] w);
		@(posedge clock);
		selLowN <= 1'h0;
		selHigh <= 1'h1;
		drive <= 1'h1;
		word <= w;
		wrN <= 1'h0;
		repeat (8) @(posedge clock);
		wrN <= 1'h1;
		selLowN <= 1'h1;
		selHigh <= 1'h0;
		repeat (8) @(posedge clock);
		drive <= 1'h0;
		repeat (8) @(posedge clock);
	endtask : hostWrite

	// read: seen records whether the device drove the bus at any of the eight edges while selected
	task automatic hostRead(input logic useRd, input logic high, output logic [11:0] w,
			output logic seen);
		seen = 1'h0;
		@(posedge clock);
		selLowN <= 1'h0;
		selHigh <= high;
		rdN <= !useRd;
		repeat (8) begin
			@(posedge clock);
			seen |= devOe;
		end
		w = busLevel;
		selLowN <= 1'h1;
		selHigh <= 1'h0;
		rdN <= 1'h1;
		repeat (8) @(posedge clock);
	endtask : hostRead
endmodule : aphi_host_model

`default_nettype wire

/* File: test/test_aphi_top.sv */
// test_aphi_top: self-checking bench of the processor-side host port
// assumes: aphi_host_model plays the processor, checker bound to aphi_top
`timescale 1ns/100ps
`default_nettype none

module test_aphi_top;
	logic        clock = 1'h0;
	logic        rstn = 1'h0;
	logic        resultValid = 1'h0;
	logic [11:0] resultData = 12'h000;
	logic        swWr = 1'h0;
	logic        swRd = 1'h0;
	logic [7:0]  swAddr = 8'h00;
	logic [15:0] swWdata = 16'h0000;
	logic        conversionStartN = 1'h1;
	logic [11:0] busIn, busOut, word, got;
	logic        busOe, selLowN, selHigh, wrN, rdN, flag, startP, tick, contMode, extRef;
	logic        irq, seen;
	logic [15:0] swRdata;
	int          miscompares = 0, checks = 0, startCnt = 0, tickCnt = 0, flagCnt = 0;

	always #2 clock = ~clock;

	aphi_top dut (
		.clock, .rstn, .ce(1'h1), .hostDataBusIn(busIn), .hostDataBusOut(busOut),
		.hostDataBusOe(busOe), .selectActiveLowN(selLowN), .selectActiveHigh(selHigh),
		.writeStrobeN(wrN), .readStrobeN(rdN), .conversionStartN, .resultReadyFlag(flag),
		.resultValid, .resultData, .convStartPulse(startP), .convClockTick(tick),
		.continuousMode(contMode), .extRefSelect(extRef), .swWr, .swRd, .swAddr, .swWdata,
		.swRdata, .irq
	);

	aphi_host_model host (
		.clock, .devWord(busOut), .devOe(busOe), .busLevel(busIn),
		.selLowN, .selHigh, .wrN, .rdN
	);

	// pulse counters, cleared by the sequence before each count
	always @(posedge clock) begin
		startCnt += startP;
		tickCnt += tick;
		flagCnt += flag;
	end

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic swWrite(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		swWr <= 1'h1;
		swAddr <= a;
		swWdata <= d;
		@(posedge clock);
		swWr <= 1'h0;
		repeat (2) @(posedge clock);
	endtask : swWrite

	// read data stand only in the cycle after the strobe
	task automatic swCheck(input logic [7:0] a, input logic [15:0] e);
		@(posedge clock);
		swRd <= 1'h1;
		swAddr <= a;
		@(posedge clock);
		swRd <= 1'h0;
		@(posedge clock);
		chk(swRdata, e);
	endtask : swCheck

	task automatic push(input logic [11:0] w);
		@(posedge clock);
		resultValid <= 1'h1;
		resultData <= w;
		@(posedge clock);
		resultValid <= 1'h0;
		repeat (4) @(posedge clock);
	endtask : push

	// one low phase and one high phase on the start pin, long enough to sync
	task automatic pinCycle;
		@(posedge clock);
		conversionStartN <= 1'h0;
		repeat (10) @(posedge clock);
		conversionStartN <= 1'h1;
		repeat (10) @(posedge clock);
	endtask : pinCycle

	// control register 1 word, select code 1 on the top lines, threshold 0
	function automatic logic [11:0] cr1Word(input logic wo, hi, pu, co);
		return {2'h1, 2'h0, 4'h0, co, pu, hi, wo};
	endfunction : cr1Word

	function automatic logic flagLevel(input logic active, input logic hi);
		return hi ? active : !active;
	endfunction : flagLevel

	task automatic end_of_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	initial begin
		void'($urandom(32'hF68E));
		repeat (3) @(posedge clock);
		rstn <= 1'h1;
		repeat (4) @(posedge clock);
		chk(flag, 1'h1);
		// a read before any write is refused and logged, and raises the interrupt once its mask bit is set
		host.hostRead(1'h1, 1'h1, got, seen);
		chk(seen, 1'h0);
		swCheck(8'h00, 16'h0008);
		swWrite(8'h04, 16'h0008);
		chk(irq, 1'h1);
		swWrite(8'h04, 16'h0000);
		chk(irq, 1'h0);
		swWrite(8'h00, 16'h000F);
		swCheck(8'h00, 16'h0000);
		// register 0 with external reference, then a write with an unused code
		host.hostWrite({2'h0, 10'h004});
		chk(extRef, 1'h1);
		host.hostWrite({2'h2, 10'h3FB});
		swCheck(8'h08, 16'h0004);
		swCheck(8'h0C, 16'h0000);
		// both strobe schemes, each with one flag polarity
		for (int m = 1; m >= 0; m--) begin
			host.hostWrite(cr1Word(m[0], !m[0], 1'h0, 1'h0));
			chk(flag, flagLevel(1'h0, !m[0]));
			word = 12'($urandom);
			push(word);
			chk(flag, flagLevel(1'h1, !m[0]));
			host.hostRead(1'h1, 1'h0, got, seen);
			chk(seen, 1'h0);
			host.hostRead(1'h0, 1'h1, got, seen);
			chk(seen, !m[0]);
			if (m == 1)
				host.hostRead(1'h1, 1'h1, got, seen);
			chk({seen, got}, {1'h1, word});
			chk(flag, flagLevel(1'h0, !m[0]));
		end
		// pulse form: one active cycle, and its rise reaches the interrupt
		host.hostWrite(cr1Word(1'h0, 1'h1, 1'h1, 1'h0));
		swWrite(8'h00, 16'h000F);
		swWrite(8'h04, 16'h0004);
		flagCnt = 0;
		word = 12'($urandom);
		push(word);
		repeat (8) @(posedge clock);
		chk(flagCnt, 1);
		chk(irq, 1'h1);
		swWrite(8'h00, 16'h0004);
		chk(irq, 1'h0);
		host.hostRead(1'h0, 1'h1, got, seen);
		chk({seen, got}, {1'h1, word});
		// a read of the empty store drives the old word and logs an underflow
		host.hostRead(1'h0, 1'h1, got, seen);
		chk({seen, got}, {1'h1, word});
		swCheck(8'h00, 16'h0002);
		// one result beyond the store size is dropped and logged
		repeat (17) push(12'($urandom));
		swCheck(8'h00, 16'h0007);
		swCheck(8'h10, 16'h0090);
		// single mode start edge, then the pin as conversion clock
		startCnt = 0;
		pinCycle;
		chk(startCnt, 1);
		host.hostWrite(cr1Word(1'h0, 1'h1, 1'h0, 1'h1));
		chk(contMode, 1'h1);
		tickCnt = 0;
		startCnt = 0;
		repeat (3) pinCycle;
		chk(tickCnt, 3);
		chk(startCnt, 0);
		end_of_test;
	end

	// watchdog far beyond the few hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		end_of_test;
	end
endmodule : test_aphi_top

`default_nettype wire
